// file: dac_link_if.sv
`timescale 1ns/1ns
interface dac_link_if;
	logic                         start;
	logic [dpll_pkg::CV_W-1:0]    word;
	logic [dpll_pkg::DIV_W-1:0]   divider;
	logic                         busy;
	logic                         done;

	modport ctrl (output start, output word, output divider, input busy, input done);
	modport serial (input start, input word, input divider, output busy, output done);
endinterface

// file: dac_model.sv
`timescale 1ns/1ns
module dac_model
(
	input  wire logic  sclk_i,
	input  wire logic  sync_n_i,
	input  wire logic  din_i,
	output logic [15:0] word_o,
	output logic        bad_o,
	output int          frames_o
);
	logic [15:0] shift_reg;
	int          bit_cnt;
	int          base_cnt;

	initial
	begin
		shift_reg = 16'h0000;
		bit_cnt = 0;
		base_cnt = 0;
		word_o = 16'h0000;
		bad_o = 1'b0;
		frames_o = 0;
	end
	// data taken on the falling serial clock edge
	always @(negedge sclk_i) if (sync_n_i === 1'b0)
	begin
		shift_reg <= {shift_reg[14:0], din_i};
		bit_cnt <= bit_cnt + 1;
	end
	always @(negedge sync_n_i) base_cnt <= bit_cnt;
	// frame ends: word kept, bit count checked
	always @(posedge sync_n_i)
	begin
		word_o <= shift_reg;
		bad_o <= (bit_cnt - base_cnt) != 16;
		frames_o <= frames_o + 1;
	end
endmodule

// file: dac_serial.sv
`timescale 1ns/1ns
module dac_serial
(
	input  wire logic   clk_i,
	input  wire logic   rst_i,
	dac_link_if.serial  link,
	output logic        sclk_o,
	output logic        sync_n_o,
	output logic        din_o
);

	logic [dpll_pkg::FRAME_BITS-1:0] shift_reg;
	logic [4:0]                      bit_reg;
	logic [dpll_pkg::DIV_W-1:0]      div_reg;
	logic [dpll_pkg::DIV_W-1:0]      div_cnt_reg;
	logic                            busy_reg;
	logic                            done_reg;
	logic                            half_tick;

	assign half_tick = (div_cnt_reg >= div_reg - 16'h0001) || (div_reg == 16'h0000);
	assign link.busy = busy_reg;
	assign link.done = done_reg;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			div_cnt_reg <= 16'h0000;
		else if (!busy_reg || half_tick)
			div_cnt_reg <= 16'h0000;
		else
			div_cnt_reg <= div_cnt_reg + 16'h0001;
	end

	// one frame per start, next start only once idle
	always_ff @(posedge clk_i)
	begin
		done_reg <= 1'b0;
		if (rst_i)
		begin
			busy_reg  <= 1'b0;
			sclk_o    <= 1'b1;
			sync_n_o  <= 1'b1;
			din_o     <= 1'b0;
			shift_reg <= 16'h0000;
			bit_reg   <= 5'h00;
			div_reg   <= dpll_pkg::DIV_RST;
		end
		else if (!busy_reg)
		begin
			sclk_o <= 1'b1;
			if (link.start)
			begin
				busy_reg  <= 1'b1;
				sync_n_o  <= 1'b0;
				shift_reg <= {4'h0, link.word} << 1;
				din_o     <= 1'b0;
				bit_reg   <= 5'(dpll_pkg::FRAME_BITS - 1);
				div_reg   <= link.divider;
			end
		end
		else if (half_tick)
		begin
			if (sclk_o)
				sclk_o <= 1'b0;
			else if (bit_reg == 5'h00)
			begin
				sclk_o   <= 1'b1;
				sync_n_o <= 1'b1;
				busy_reg <= 1'b0;
				done_reg <= 1'b1;
			end
			else
			begin
				sclk_o    <= 1'b1;
				din_o     <= shift_reg[dpll_pkg::FRAME_BITS-1];
				shift_reg <= shift_reg << 1;
				bit_reg   <= bit_reg - 5'h01;
			end
		end
	end

endmodule

// file: dpll_core.sv
// Local design decisions: register access over Wishbone and the register offsets.
`timescale 1ns/1ns
// Overview of operation
// - proportional path plus integrating path in filter
// - first-order gain from 8-bit beta
// - second-order gain from 8-bit alpha
// - detector error gives direction and magnitude
// - select 1 frequency, 0 bang-bang detector
// - readable error of selected detector
// - reference counter bit select
// - control word shifted out to DAC
// - divider sets serial bit clock rate
// - everything clocked by the VCO clock
// - open loop sends fixed control value
// - sticky out-of-lock flag
// - lock clear clears the sticky flag
// - reset control reinitialises loop logic
// - closed-loop select 1 closed, 0 fixed
// - VCO counter bit select
module dpll_core
(
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	input  wire logic                          wb_cyc_i,
	input  wire logic                          wb_stb_i,
	input  wire logic                          wb_we_i,
	input  wire logic [dpll_pkg::ADDR_W-1:0]   wb_adr_i,
	input  wire logic [dpll_pkg::DATA_W-1:0]   wb_dat_i,
	input  wire logic [3:0]                    wb_sel_i,
	output logic      [dpll_pkg::DATA_W-1:0]   wb_dat_o,
	output logic                               wb_ack_o,
	input  wire logic                          ref_i,
	output logic                               dac_sclk_o,
	output logic                               dac_sync_n_o,
	output logic                               dac_din_o,
	output logic                               irq_o
);

	logic                             det_sel_reg;
	logic                             closed_reg;
	logic                             loop_rst_reg;
	logic                             lock_clr;
	logic [dpll_pkg::GAIN_W-1:0]      beta_reg;
	logic [dpll_pkg::GAIN_W-1:0]      alpha_reg;
	logic [dpll_pkg::DIV_W-1:0]       div_reg;
	logic [dpll_pkg::CV_W-1:0]        fixed_reg;
	logic [dpll_pkg::SEL_W-1:0]       refsel_reg;
	logic [dpll_pkg::SEL_W-1:0]       vcosel_reg;
	logic [dpll_pkg::IRQ_W-1:0]       irq_stat_reg;
	logic [dpll_pkg::IRQ_W-1:0]       irq_stat_next;
	logic [dpll_pkg::IRQ_W-1:0]       irq_mask_reg;
	logic                             wr_en;
	logic [dpll_pkg::DATA_W-1:0]      wmask;
	logic [dpll_pkg::DATA_W-1:0]      wdat;

	logic                             loop_rst;
	logic                             ref_s1_reg;
	logic                             ref_s2_reg;
	logic                             ref_d_reg;
	logic                             ref_rise;
	logic [dpll_pkg::CNT_W-1:0]       ref_cnt_reg;
	logic [dpll_pkg::CNT_W-1:0]       vco_cnt_reg;
	logic                             ref_bit_d_reg;
	logic                             vco_bit_d_reg;
	logic                             ref_bit;
	logic                             vco_bit;
	logic signed [dpll_pkg::ERR_W-1:0] bb_acc_reg;
	logic signed [dpll_pkg::ERR_W-1:0] fd_acc_reg;
	logic signed [dpll_pkg::ERR_W-1:0] bb_vote;
	logic signed [dpll_pkg::ERR_W-1:0] fd_vote;
	logic signed [dpll_pkg::ERR_W-1:0] err_sel;
	logic signed [dpll_pkg::ERR_W-1:0] err_reg;
	logic signed [dpll_pkg::ACC_W-1:0] integ_reg;
	logic signed [dpll_pkg::ACC_W-1:0] err_wide;
	logic signed [dpll_pkg::ACC_W-1:0] sum;
	logic [dpll_pkg::CV_W-1:0]        cv_reg;
	logic                             ool_reg;
	logic                             ool_event;
	dpll_pkg::loop_state_t            state_reg;

	dac_link_if link ();

	function automatic logic [dpll_pkg::DATA_W-1:0] lane_mask(input logic [3:0] sel);
		lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction

	function automatic logic signed [dpll_pkg::ACC_W-1:0] acc_ext(input logic signed [dpll_pkg::ERR_W-1:0] v);
		acc_ext = {{(dpll_pkg::ACC_W-dpll_pkg::ERR_W){v[dpll_pkg::ERR_W-1]}}, v};
	endfunction

	assign wdat     = wb_dat_i;
	assign wr_en    = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
	assign wmask    = lane_mask(wb_sel_i);
	assign lock_clr = wr_en && (wb_adr_i == dpll_pkg::ADR_CTRL) && wmask[dpll_pkg::CTRL_LOCK_CLR]
		&& wb_dat_i[dpll_pkg::CTRL_LOCK_CLR];
	assign loop_rst = rst_i || loop_rst_reg;

	// bus answer one cycle after request, drops the cycle after
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_dat_o <= 32'h0000_0000;
		else if (wb_cyc_i && wb_stb_i && !wb_ack_o)
		begin
			if (wb_adr_i == dpll_pkg::ADR_CTRL)
				wb_dat_o <= {30'h0000_0000, closed_reg, det_sel_reg};
			else if (wb_adr_i == dpll_pkg::ADR_GAIN)
				wb_dat_o <= {16'h0000, alpha_reg, beta_reg};
			else if (wb_adr_i == dpll_pkg::ADR_DIV)
				wb_dat_o <= {16'h0000, div_reg};
			else if (wb_adr_i == dpll_pkg::ADR_FIXED)
				wb_dat_o <= {20'h0_0000, fixed_reg};
			else if (wb_adr_i == dpll_pkg::ADR_BITSEL)
				wb_dat_o <= {21'h00_0000, vcosel_reg, 5'h00, refsel_reg};
			else if (wb_adr_i == dpll_pkg::ADR_STATUS)
				wb_dat_o <= {err_sel, 15'h0000, ool_reg};
			else if (wb_adr_i == dpll_pkg::ADR_CV)
				wb_dat_o <= {20'h0_0000, cv_reg};
			else if (wb_adr_i == dpll_pkg::ADR_IRQ_STAT)
				wb_dat_o <= {30'h0000_0000, irq_stat_reg};
			else if (wb_adr_i == dpll_pkg::ADR_IRQ_MASK)
				wb_dat_o <= {30'h0000_0000, irq_mask_reg};
			else
				wb_dat_o <= 32'h0000_0000;
		end
	end

	// configuration writes, byte lanes honoured
	always_ff @(posedge clk_i)
	begin
		loop_rst_reg <= 1'b0;
		if (rst_i)
		begin
			det_sel_reg  <= 1'b0;
			closed_reg   <= 1'b1;
			beta_reg     <= dpll_pkg::BETA_RST;
			alpha_reg    <= dpll_pkg::ALPHA_RST;
			div_reg      <= dpll_pkg::DIV_RST;
			fixed_reg    <= dpll_pkg::FIXED_RST;
			refsel_reg   <= dpll_pkg::REFSEL_RST;
			vcosel_reg   <= dpll_pkg::VCOSEL_RST;
			irq_mask_reg <= 2'h0;
		end
		else if (wr_en)
		begin
			if (wb_adr_i == dpll_pkg::ADR_CTRL && wb_sel_i[0])
			begin
				det_sel_reg  <= wdat[dpll_pkg::CTRL_DET_SEL];
				closed_reg   <= wdat[dpll_pkg::CTRL_CLOSED];
				loop_rst_reg <= wdat[dpll_pkg::CTRL_LOOP_RST];
			end
			else if (wb_adr_i == dpll_pkg::ADR_GAIN)
			begin
				if (wb_sel_i[0])
					beta_reg <= wdat[dpll_pkg::GAIN_BETA_LSB +: 8];
				if (wb_sel_i[1])
					alpha_reg <= wdat[dpll_pkg::GAIN_ALPHA_LSB +: 8];
			end
			else if (wb_adr_i == dpll_pkg::ADR_DIV)
				div_reg <= (div_reg & ~wmask[15:0]) | (wdat[15:0] & wmask[15:0]);
			else if (wb_adr_i == dpll_pkg::ADR_FIXED)
				fixed_reg <= (fixed_reg & ~wmask[11:0]) | (wdat[11:0] & wmask[11:0]);
			else if (wb_adr_i == dpll_pkg::ADR_BITSEL)
			begin
				if (wb_sel_i[0])
					refsel_reg <= wdat[dpll_pkg::BITSEL_REF_LSB +: 3];
				if (wb_sel_i[1])
					vcosel_reg <= wdat[dpll_pkg::BITSEL_VCO_LSB +: 3];
			end
			else if (wb_adr_i == dpll_pkg::ADR_IRQ_MASK && wb_sel_i[0])
				irq_mask_reg <= wdat[1:0];
		end
	end

	// reference pin synchroniser and edge detect
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ref_s1_reg <= 1'b0;
			ref_s2_reg <= 1'b0;
			ref_d_reg  <= 1'b0;
		end
		else
		begin
			ref_s1_reg <= ref_i;
			ref_s2_reg <= ref_s1_reg;
			ref_d_reg  <= ref_s2_reg;
		end
	end
	assign ref_rise = ref_s2_reg && !ref_d_reg;

	// free-running counters, all on the VCO clock
	always_ff @(posedge clk_i)
	begin
		if (loop_rst)
		begin
			ref_cnt_reg   <= 8'h00;
			vco_cnt_reg   <= 8'h00;
			ref_bit_d_reg <= 1'b0;
			vco_bit_d_reg <= 1'b0;
		end
		else
		begin
			ref_cnt_reg   <= ref_cnt_reg + {7'h00, ref_rise};
			vco_cnt_reg   <= vco_cnt_reg + 8'h01;
			ref_bit_d_reg <= ref_bit;
			vco_bit_d_reg <= vco_bit;
		end
	end
	assign ref_bit = ref_cnt_reg[refsel_reg];
	assign vco_bit = vco_cnt_reg[vcosel_reg];

	// signed votes: sign is direction, accumulated count is speed
	always_comb
	begin
		bb_vote = 16'sh0000;
		if (ref_rise)
			bb_vote = vco_bit ? -16'sh0001 : 16'sh0001;
		fd_vote = 16'sh0000;
		if ((ref_bit != ref_bit_d_reg) && (vco_bit == vco_bit_d_reg))
			fd_vote = 16'sh0001;
		else if ((ref_bit == ref_bit_d_reg) && (vco_bit != vco_bit_d_reg))
			fd_vote = -16'sh0001;
	end

	assign err_sel = det_sel_reg ? fd_acc_reg : bb_acc_reg;

	// accumulators dumped into the filter each update
	always_ff @(posedge clk_i)
	begin
		if (loop_rst)
		begin
			bb_acc_reg <= 16'sh0000;
			fd_acc_reg <= 16'sh0000;
		end
		else if (state_reg == dpll_pkg::LOOP_CAPTURE)
		begin
			bb_acc_reg <= bb_vote;
			fd_acc_reg <= fd_vote;
		end
		else
		begin
			bb_acc_reg <= bb_acc_reg + bb_vote;
			fd_acc_reg <= fd_acc_reg + fd_vote;
		end
	end

	assign err_wide = acc_ext(err_reg);
	assign sum = $signed({28'h000_0000, dpll_pkg::CV_MID}) + (integ_reg >>> alpha_reg)
		+ ((err_wide <<< dpll_pkg::PROP_SHIFT) >>> beta_reg);

	// update sequence: capture, filter, send, wait for frame end
	always_ff @(posedge clk_i)
	begin
		if (loop_rst)
		begin
			state_reg <= dpll_pkg::LOOP_CAPTURE;
			err_reg   <= 16'sh0000;
			integ_reg <= 40'sh00_0000_0000;
			cv_reg    <= dpll_pkg::CV_MID;
			ool_event <= 1'b0;
		end
		else
		begin
			ool_event <= 1'b0;
			case (state_reg)
				dpll_pkg::LOOP_CAPTURE:
				begin
					err_reg   <= err_sel;
					state_reg <= dpll_pkg::LOOP_FILTER;
				end
				dpll_pkg::LOOP_FILTER:
				begin
					integ_reg <= integ_reg + (err_wide <<< dpll_pkg::INT_SHIFT);
					if (sum < 0)
						cv_reg <= 12'h000;
					else if (sum > $signed({28'h000_0000, dpll_pkg::CV_MAX}))
						cv_reg <= dpll_pkg::CV_MAX;
					else
						cv_reg <= sum[dpll_pkg::CV_W-1:0];
					ool_event <= (sum < 0) || (sum > $signed({28'h000_0000, dpll_pkg::CV_MAX}))
						|| (err_reg > $signed(dpll_pkg::LOCK_LIMIT)) || (-err_reg > $signed(dpll_pkg::LOCK_LIMIT));
					state_reg <= dpll_pkg::LOOP_SEND;
				end
				dpll_pkg::LOOP_SEND:
					state_reg <= dpll_pkg::LOOP_WAIT;
				default:
					if (link.done)
						state_reg <= dpll_pkg::LOOP_CAPTURE;
			endcase
		end
	end

	assign link.start   = (state_reg == dpll_pkg::LOOP_SEND) && !link.busy;
	assign link.word    = closed_reg ? cv_reg : fixed_reg;
	assign link.divider = div_reg;

	// sticky out-of-lock, a new loss wins over a clear
	always_ff @(posedge clk_i)
	begin
		if (loop_rst)
			ool_reg <= 1'b0;
		else if (ool_event)
			ool_reg <= 1'b1;
		else if (lock_clr)
			ool_reg <= 1'b0;
	end

	always_comb
	begin
		irq_stat_next = irq_stat_reg;
		if (wr_en && wb_adr_i == dpll_pkg::ADR_IRQ_STAT && wb_sel_i[0])
			irq_stat_next = irq_stat_next & ~wb_dat_i[1:0];
		if (ool_event)
			irq_stat_next[dpll_pkg::IRQ_OOL] = 1'b1;
		if (link.done)
			irq_stat_next[dpll_pkg::IRQ_FRAME] = 1'b1;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			irq_stat_reg <= 2'h0;
			irq_o        <= 1'b0;
		end
		else
		begin
			irq_stat_reg <= irq_stat_next;
			irq_o        <= |(irq_stat_next & irq_mask_reg);
		end
	end

	dac_serial u_dac_serial
	(
		.clk_i    (clk_i),
		.rst_i    (loop_rst),
		.link     (link.serial),
		.sclk_o   (dac_sclk_o),
		.sync_n_o (dac_sync_n_o),
		.din_o    (dac_din_o)
	);

endmodule

// file: dpll_core_checker.sv
`timescale 1ns/1ns
module dpll_core_checker
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic wb_cyc_i,
	input  wire logic wb_stb_i,
	input  wire logic wb_ack_o,
	input  wire logic dac_sclk_o,
	input  wire logic dac_sync_n_o,
	input  wire logic dac_din_o,
	input  wire logic irq_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing after request");
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && dac_sync_n_o && dac_sclk_o && !irq_o)
		else $error("outputs not idle in reset");
	a_idle_sclk_high: assert property (dac_sync_n_o |-> dac_sclk_o)
		else $error("serial clock not idle high");
	a_frame_gap: assert property ($rose(dac_sync_n_o) |=> dac_sync_n_o [*2])
		else $error("frames overlap");
	a_frame_lead_zero: assert property ($fell(dac_sync_n_o) |-> !dac_din_o && dac_sclk_o)
		else $error("bad frame start");
	a_din_hold_low: assert property (!dac_sclk_o && $past(!dac_sclk_o) |-> $stable(dac_din_o))
		else $error("data moved while clock low");
endmodule

bind dpll_core dpll_core_checker chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .dac_sclk_o(dac_sclk_o), .dac_sync_n_o(dac_sync_n_o), .dac_din_o(dac_din_o),
	.irq_o(irq_o));

// file: dpll_core_tb.sv
`timescale 1ns/1ns
module dpll_core_tb;
	logic        clk_i, rst_i, cyc, stb, we, ref_i, ref_run, ack, sclk, sync_n, din, irq, dbad;
	logic [7:0]  adr;
	logic [31:0] wdat, rdat, q, seed;
	logic [15:0] dword, dv;
	logic [11:0] fx;
	logic [7:0]  beta;
	logic [1:0]  rc;
	int          frames, n_fail, check_count, cycles, i, n;

	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	dpll_core dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(rdat), .wb_ack_o(ack), .ref_i(ref_i), .dac_sclk_o(sclk),
		.dac_sync_n_o(sync_n), .dac_din_o(din), .irq_o(irq));
	dac_model dac (.sclk_i(sclk), .sync_n_i(sync_n), .din_i(din), .word_o(dword), .bad_o(dbad), .frames_o(frames));

	// reference toggles every third clock when running
	always @(posedge clk_i) if (ref_run)
	begin
		rc <= (rc == 2'h2) ? 2'h0 : rc + 2'h1;
		if (rc == 2'h2) ref_i <= ~ref_i;
	end

	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			n_fail++;
			print_verdict();
		end
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [15:0] exp_word(input logic [11:0] v);
		return {4'h0, v};
	endfunction

	task automatic print_verdict();
		$display("checks %0d fails %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		k = 0;
		do
		begin
			@(posedge clk_i);
			k++;
		end
		while (ack !== 1'b1 && k < 20);
		if (k == 20) chk(32'h0, 32'h1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask

	task automatic wait_frames(input int m);
		int f0, k;
		f0 = frames;
		k = 0;
		while (frames < f0 + m && k < 3000)
		begin
			@(posedge clk_i);
			k++;
		end
		if (k == 3000) chk(32'h0, 32'h1);
	endtask

	task automatic half_period(input logic [15:0] exp);
		int k;
		@(negedge sclk);
		k = 0;
		while (sclk === 1'b0 && k < 100)
		begin
			@(posedge clk_i);
			#1;
			k++;
		end
		chk(k, {16'h0, exp});
	endtask

	initial
	begin
		rst_i = 1'b1;
		{cyc, stb, we, ref_i, ref_run, rc, adr, wdat} = '0;
		seed = 32'h0000CA23;
		{n_fail, check_count, cycles} = '0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(dpll_pkg::ADR_CTRL, 32'h2);
		rd(dpll_pkg::ADR_GAIN, {16'h0, dpll_pkg::ALPHA_RST, dpll_pkg::BETA_RST});
		rd(dpll_pkg::ADR_DIV, {16'h0, dpll_pkg::DIV_RST});
		rd(dpll_pkg::ADR_FIXED, {20'h0, dpll_pkg::FIXED_RST});
		rd(dpll_pkg::ADR_BITSEL, 32'h0);
		wb(1'b1, 8'h40, 32'hFFFFFFFF);
		rd(8'h40, 32'h0);
		for (i = 0; i < 4; i++)
		begin
			dv = 16'(1 + rnd() % 4);
			fx = (i == 0) ? 12'hFFF : 12'(rnd());
			beta = 8'(rnd() % 6);
			wb(1'b1, dpll_pkg::ADR_DIV, {16'h0, dv});
			wb(1'b1, dpll_pkg::ADR_FIXED, {20'h0, fx});
			wb(1'b1, dpll_pkg::ADR_GAIN, {16'h0, 8'h09, beta});
			wb(1'b1, dpll_pkg::ADR_CTRL, 32'h0);
			wait_frames(2);
			chk(dword, exp_word(fx));
			chk(dbad, 1'b0);
			half_period(dv);
			rd(dpll_pkg::ADR_GAIN, {16'h0, 8'h09, beta});
		end
		wb(1'b1, dpll_pkg::ADR_IRQ_STAT, 32'h3);
		wb(1'b1, dpll_pkg::ADR_IRQ_MASK, 32'h2);
		wait_frames(1);
		repeat (2) @(posedge clk_i);
		chk(irq, 1'b1);
		rd(dpll_pkg::ADR_IRQ_STAT, 32'h2);
		wb(1'b1, dpll_pkg::ADR_IRQ_MASK, 32'h0);
		repeat (2) @(posedge clk_i);
		chk(irq, 1'b0);
		ref_run <= 1'b1;
		wb(1'b1, dpll_pkg::ADR_CTRL, 32'h7);
		repeat (400) @(posedge clk_i);
		wb(1'b0, dpll_pkg::ADR_STATUS, 32'h0);
		chk(q[31], 1'b1);
		wb(1'b1, dpll_pkg::ADR_BITSEL, 32'h00000700);
		wb(1'b1, dpll_pkg::ADR_CTRL, 32'h7);
		repeat (400) @(posedge clk_i);
		wb(1'b0, dpll_pkg::ADR_STATUS, 32'h0);
		chk(q[31], 1'b0);
		wb(1'b1, dpll_pkg::ADR_BITSEL, 32'h0);
		wb(1'b1, dpll_pkg::ADR_DIV, 32'h40);
		wb(1'b1, dpll_pkg::ADR_CTRL, 32'h6);
		n = 0;
		do
		begin
			wb(1'b0, dpll_pkg::ADR_STATUS, 32'h0);
			n++;
		end
		while (q[0] !== 1'b1 && n < 1500);
		chk(q[0], 1'b1);
		wb(1'b1, dpll_pkg::ADR_CTRL, 32'hA);
		wb(1'b0, dpll_pkg::ADR_STATUS, 32'h0);
		chk(q[0], 1'b0);
		ref_run <= 1'b0;
		wb(1'b1, dpll_pkg::ADR_DIV, 32'h4);
		wb(1'b1, dpll_pkg::ADR_CTRL, 32'h6);
		wb(1'b0, dpll_pkg::ADR_STATUS, 32'h0);
		chk(q[0], 1'b0);
		wait_frames(2);
		chk(dbad, 1'b0);
		print_verdict();
	end
endmodule

// file: dpll_pkg.sv
package dpll_pkg;

	localparam int          DATA_W       = 32;
	localparam int          ADDR_W       = 8;
	localparam int          CV_W         = 12;
	localparam int          GAIN_W       = 8;
	localparam int          DIV_W        = 16;
	localparam int          ERR_W        = 16;
	localparam int          CNT_W        = 8;
	localparam int          SEL_W        = 3;
	localparam int          ACC_W        = 40;
	localparam int          FRAME_BITS   = 16;

	localparam logic [7:0]  ADR_CTRL     = 8'h00;
	localparam logic [7:0]  ADR_GAIN     = 8'h04;
	localparam logic [7:0]  ADR_DIV      = 8'h08;
	localparam logic [7:0]  ADR_FIXED    = 8'h0C;
	localparam logic [7:0]  ADR_BITSEL   = 8'h10;
	localparam logic [7:0]  ADR_STATUS   = 8'h14;
	localparam logic [7:0]  ADR_CV       = 8'h18;
	localparam logic [7:0]  ADR_IRQ_STAT = 8'h1C;
	localparam logic [7:0]  ADR_IRQ_MASK = 8'h20;

	localparam int          CTRL_DET_SEL   = 0;
	localparam int          CTRL_CLOSED    = 1;
	localparam int          CTRL_LOOP_RST  = 2;
	localparam int          CTRL_LOCK_CLR  = 3;
	localparam int          GAIN_BETA_LSB  = 0;
	localparam int          GAIN_ALPHA_LSB = 8;
	localparam int          BITSEL_REF_LSB = 0;
	localparam int          BITSEL_VCO_LSB = 8;
	localparam int          STAT_OOL       = 0;
	localparam int          STAT_ERR_LSB   = 16;
	localparam int          IRQ_OOL        = 0;
	localparam int          IRQ_FRAME      = 1;
	localparam int          IRQ_W          = 2;

	localparam logic [7:0]  BETA_RST     = 8'h04;
	localparam logic [7:0]  ALPHA_RST    = 8'h09;
	localparam logic [15:0] DIV_RST      = 16'h0004;
	localparam logic [11:0] FIXED_RST    = 12'h800;
	localparam logic [11:0] CV_MID       = 12'h800;
	localparam logic [11:0] CV_MAX       = 12'hFFF;
	localparam logic [2:0]  REFSEL_RST   = 3'h0;
	localparam logic [2:0]  VCOSEL_RST   = 3'h0;
	localparam int          PROP_SHIFT   = 8;
	localparam int          INT_SHIFT    = 16;
	localparam logic [15:0] LOCK_LIMIT   = 16'h0100;

	typedef enum logic [1:0] {
		LOOP_CAPTURE,
		LOOP_FILTER,
		LOOP_SEND,
		LOOP_WAIT
	} loop_state_t;

endpackage
